/* File: qcs_top.sv */
// Overview of operation
// - global enable turns classification on or off
// - trust CoS uses tag priority, else default
// - trust DSCP maps IP, non-IP best effort
// - combined mode: IP by DSCP, others by tag
// - precedence mode uses precedence-to-queue table
// - untrusted port sends everything best effort
// - per-port default priority for untagged frames
// - priority remark from queue-to-priority table
// - separate DSCP and precedence remark enables
// - eight egress queues per interface
// - higher queue number means higher priority
// - strict serves highest non-empty queue first
// - round robin serves queue until quota spent
// - per-queue strict or round robin, strict first
// - weight only used by round robin queues
// - report round robin bandwidth percentage per queue
// - priority-to-queue table for CoS trust
// - DSCP-to-queue table, tag priority kept
// - queue-to-DSCP table for DSCP remark
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module qcs_top (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// register bus write channels
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// register bus read channels
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// ingress frame descriptor
	input wire logic inValid,
	input wire logic [2:0] inPort,
	input wire logic inTagged,
	input wire logic [2:0] inPrio,
	input wire logic inIsIp,
	input wire logic [5:0] inDscp,
	// classification result
	output logic clsValid,
	output logic [2:0] clsPort,
	output logic [2:0] clsQueue,
	// egress queue selection
	input wire logic txPick,
	input wire logic [7:0] queueNonEmpty,
	output logic pickValid,
	output logic [2:0] pickQueue,
	// egress remark
	input wire logic egValid,
	input wire logic [2:0] egPort,
	input wire logic [2:0] egQueue,
	input wire logic egIsIp,
	input wire logic [2:0] egPrio,
	input wire logic [5:0] egDscp,
	output logic rmkValid,
	output logic [2:0] rmkPrio,
	output logic [5:0] rmkDscp
);
	logic [2:0] ctrl_q;
	logic [23:0] p2q_q;
	logic [23:0] q2p_q;
	logic [23:0] pr2q_q;
	logic [23:0] q2pr_q;
	logic [7:0] strict_q;
	logic [6:0] port_q [qcs_pkg::NPORT];
	logic [7:0] wgt_q [qcs_pkg::NQ];
	logic [5:0] q2d_q [qcs_pkg::NQ];
	logic [2:0] d2q_q [qcs_pkg::NDSCP];
	logic [63:0] wgtFlat;
	logic [10:0] wrrSum;
	logic [16:0] bwNum;
	logic wrEn;
	logic rdEn;
	logic [31:0] rdD;
	logic rdHit;
	logic qosOn;
	qcs_pkg::qcs_trust_type mode;
	logic [6:0] inCfg;
	logic [2:0] effPrio;
	logic [2:0] cosQ;
	logic [2:0] clsD;
	logic [6:0] egCfg;

	// ==========================================================
	// helpers
	// byte-lane merge so partial writes keep untouched lanes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// word window test, aligned words only
	function automatic logic inWin(input logic [11:0] a,
		input logic [11:0] base, input int n);
		return (a >= base) && ({20'h0, a} < {20'h0, base} + 32'(4 * n))
			&& (a[1:0] == 2'h0);
	endfunction

	// 3-bit entry out of an eight-entry packed table
	function automatic logic [2:0] tab3(input logic [23:0] t,
		input logic [2:0] i);
		return t[i*3 +: 3];
	endfunction

	// ==========================================================
	// bus handshakes
	// address and data taken together; one write answer at a time
	assign wrEn = awvalid && wvalid && !bvalid;
	assign awready = wrEn;
	assign wready = wrEn;
	assign rdEn = arvalid && !rvalid;
	assign arready = !rvalid;

	// write answer, read-only offsets and anything outside the aligned 0x000-0x1fc words get an error
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= qcs_pkg::RESP_OKAY;
		end else if (wrEn) begin
			bvalid <= 1'b1;
			if (awaddr == qcs_pkg::ADDR_STAT
				|| inWin(awaddr, qcs_pkg::ADDR_BW, qcs_pkg::NQ)
				|| !inWin(awaddr, 12'h000, 128))
				bresp <= qcs_pkg::RESP_SLVERR;
			else
				bresp <= qcs_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// global and packed tables
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= qcs_pkg::RST_CTRL;
			p2q_q <= qcs_pkg::RST_IDENT;
			q2p_q <= qcs_pkg::RST_IDENT;
			pr2q_q <= qcs_pkg::RST_IDENT;
			q2pr_q <= qcs_pkg::RST_IDENT;
			strict_q <= qcs_pkg::RST_STRICT;
		end else if (wrEn) begin
			unique case (awaddr)
				qcs_pkg::ADDR_CTRL:
					ctrl_q <= 3'(merge(32'(ctrl_q), wdata, wstrb));
				qcs_pkg::ADDR_P2Q:
					p2q_q <= 24'(merge(32'(p2q_q), wdata, wstrb));
				qcs_pkg::ADDR_Q2P:
					q2p_q <= 24'(merge(32'(q2p_q), wdata, wstrb));
				qcs_pkg::ADDR_PR2Q:
					pr2q_q <= 24'(merge(32'(pr2q_q), wdata, wstrb));
				qcs_pkg::ADDR_Q2PR:
					q2pr_q <= 24'(merge(32'(q2pr_q), wdata, wstrb));
				qcs_pkg::ADDR_STRICT:
					strict_q <= 8'(merge(32'(strict_q), wdata, wstrb));
				default: ;
			endcase
		end
	end

	// per-port settings: default priority, trust, remark enables
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < qcs_pkg::NPORT; p++)
				port_q[p] <= qcs_pkg::RST_PORT;
		end else if (wrEn && inWin(awaddr, qcs_pkg::ADDR_PORT,
			qcs_pkg::NPORT)) begin
			port_q[awaddr[4:2]] <=
				7'(merge(32'(port_q[awaddr[4:2]]), wdata, wstrb));
		end
	end

	// per-queue weight and remark DSCP
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int q = 0; q < qcs_pkg::NQ; q++) begin
				wgt_q[q] <= qcs_pkg::RST_WGT;
				q2d_q[q] <= qcs_pkg::RST_Q2D;
			end
		end else if (wrEn) begin
			if (inWin(awaddr, qcs_pkg::ADDR_WGT, qcs_pkg::NQ))
				wgt_q[awaddr[4:2]] <=
					8'(merge(32'(wgt_q[awaddr[4:2]]), wdata, wstrb));
			if (inWin(awaddr, qcs_pkg::ADDR_Q2D, qcs_pkg::NQ))
				q2d_q[awaddr[4:2]] <=
					6'(merge(32'(q2d_q[awaddr[4:2]]), wdata, wstrb));
		end
	end

	// DSCP-to-queue table, one word per DSCP value
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int d = 0; d < qcs_pkg::NDSCP; d++)
				d2q_q[d] <= 3'(d >> 3);
		end else if (wrEn && inWin(awaddr, qcs_pkg::ADDR_D2Q,
			qcs_pkg::NDSCP)) begin
			d2q_q[awaddr[7:2]] <=
				3'(merge(32'(d2q_q[awaddr[7:2]]), wdata, wstrb));
		end
	end

	// ==========================================================
	// round robin share
	// weights of strict queues drop out of the denominator
	always_comb begin
		wrrSum = 11'h000;
		wgtFlat = 64'h0;
		for (int q = 0; q < qcs_pkg::NQ; q++) begin
			wgtFlat[q*8 +: 8] = wgt_q[q];
			if (!strict_q[q])
				wrrSum = wrrSum + 11'(wgt_q[q]);
		end
		bwNum = 17'(wgt_q[araddr[4:2]]) * qcs_pkg::PERCENT_FULL;
	end

	// ==========================================================
	// read mux
	always_comb begin
		rdD = 32'h0;
		rdHit = 1'b1;
		if (araddr == qcs_pkg::ADDR_CTRL)
			rdD = 32'(ctrl_q);
		else if (araddr == qcs_pkg::ADDR_P2Q)
			rdD = 32'(p2q_q);
		else if (araddr == qcs_pkg::ADDR_Q2P)
			rdD = 32'(q2p_q);
		else if (araddr == qcs_pkg::ADDR_PR2Q)
			rdD = 32'(pr2q_q);
		else if (araddr == qcs_pkg::ADDR_Q2PR)
			rdD = 32'(q2pr_q);
		else if (araddr == qcs_pkg::ADDR_STRICT)
			rdD = 32'(strict_q);
		else if (araddr == qcs_pkg::ADDR_STAT)
			rdD = {21'h0, pickQueue, queueNonEmpty};
		else if (inWin(araddr, qcs_pkg::ADDR_PORT, qcs_pkg::NPORT))
			rdD = 32'(port_q[araddr[4:2]]);
		else if (inWin(araddr, qcs_pkg::ADDR_WGT, qcs_pkg::NQ))
			rdD = 32'(wgt_q[araddr[4:2]]);
		else if (inWin(araddr, qcs_pkg::ADDR_BW, qcs_pkg::NQ)) begin
			// strict queues and an empty weight sum read zero
			if (!strict_q[araddr[4:2]] && wrrSum != 11'h000)
				rdD = 32'(bwNum / 17'(wrrSum));
		end else if (inWin(araddr, qcs_pkg::ADDR_Q2D, qcs_pkg::NQ))
			rdD = 32'(q2d_q[araddr[4:2]]);
		else if (inWin(araddr, qcs_pkg::ADDR_D2Q, qcs_pkg::NDSCP))
			rdD = 32'(d2q_q[araddr[7:2]]);
		else
			rdHit = 1'b0;
	end

	// read answer held until rready
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= qcs_pkg::RESP_OKAY;
		end else if (rdEn) begin
			rvalid <= 1'b1;
			rdata <= rdD;
			rresp <= rdHit ? qcs_pkg::RESP_OKAY : qcs_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// ingress classification
	// tables are read live, so a change hits the next frame
	assign qosOn = ctrl_q[qcs_pkg::CTRL_EN_BIT];
	assign mode = qcs_pkg::qcs_trust_type'(
		ctrl_q[qcs_pkg::CTRL_MODE_LSB +: 2]);
	assign inCfg = port_q[inPort];

	always_comb begin
		effPrio = inTagged ? inPrio : inCfg[2:0];
		cosQ = tab3(p2q_q, effPrio);
		clsD = qcs_pkg::BEST_EFFORT_Q;
		unique case (mode)
			qcs_pkg::TRUST_COS:
				clsD = cosQ;
			qcs_pkg::TRUST_DSCP:
				clsD = inIsIp ? d2q_q[inDscp]
					: qcs_pkg::BEST_EFFORT_Q;
			qcs_pkg::TRUST_TAG_OR_DIFFSERV:
				clsD = inIsIp ? d2q_q[inDscp] : cosQ;
			qcs_pkg::TRUST_PREC:
				clsD = inIsIp ? tab3(pr2q_q, inDscp[5:3])
					: qcs_pkg::BEST_EFFORT_Q;
		endcase
		// off or untrusting port: everything best effort
		if (!qosOn || !inCfg[qcs_pkg::PORT_TRUST_BIT])
			clsD = qcs_pkg::BEST_EFFORT_Q;
	end

	// registered result goes to the enqueue stage
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clsValid <= 1'b0;
			clsPort <= 3'h0;
			clsQueue <= qcs_pkg::BEST_EFFORT_Q;
		end else begin
			clsValid <= inValid;
			if (inValid) begin
				clsPort <= inPort;
				clsQueue <= clsD;
			end
		end
	end

	// ==========================================================
	// egress scheduler over the eight queues
	qcs_sched u_sched (
		.mclk(mclk),
		.nrst(nrst),
		.pickReq(txPick),
		.nonEmpty(queueNonEmpty),
		.strictMask(strict_q),
		.weights(wgtFlat),
		.pickValid(pickValid),
		.pickQueue(pickQueue)
	);

	// ==========================================================
	// egress remark
	// tag priority passes unchanged unless QoS and its remark are both on
	assign egCfg = port_q[egPort];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rmkValid <= 1'b0;
			rmkPrio <= 3'h0;
			rmkDscp <= 6'h00;
		end else begin
			rmkValid <= egValid;
			if (egValid) begin
				if (qosOn && egCfg[qcs_pkg::PORT_RMK_PRIO_BIT])
					rmkPrio <= tab3(q2p_q, egQueue);
				else
					rmkPrio <= egPrio;
				if (egIsIp && qosOn && egCfg[qcs_pkg::PORT_RMK_DSCP_BIT])
					rmkDscp[2:0] <= q2d_q[egQueue][2:0];
				else
					rmkDscp[2:0] <= egDscp[2:0];
				// precedence remark overrides top bits of DSCP remark
				if (egIsIp && qosOn && egCfg[qcs_pkg::PORT_RMK_PREC_BIT])
					rmkDscp[5:3] <= tab3(q2pr_q, egQueue);
				else if (egIsIp && qosOn
					&& egCfg[qcs_pkg::PORT_RMK_DSCP_BIT])
					rmkDscp[5:3] <= q2d_q[egQueue][5:3];
				else
					rmkDscp[5:3] <= egDscp[5:3];
			end
		end
	end

endmodule

/* File: qcs_pkg.sv */
package qcs_pkg;

	// ==========================================================
	// sizes
	localparam int NQ = 8;
	localparam int NPORT = 8;
	localparam int NDSCP = 64;
	localparam logic [16:0] PERCENT_FULL = 17'h00064;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_P2Q = 12'h004;
	localparam logic [11:0] ADDR_Q2P = 12'h008;
	localparam logic [11:0] ADDR_PR2Q = 12'h00c;
	localparam logic [11:0] ADDR_Q2PR = 12'h010;
	localparam logic [11:0] ADDR_STRICT = 12'h014;
	localparam logic [11:0] ADDR_STAT = 12'h018;
	localparam logic [11:0] ADDR_PORT = 12'h040;
	localparam logic [11:0] ADDR_WGT = 12'h080;
	localparam logic [11:0] ADDR_BW = 12'h0a0;
	localparam logic [11:0] ADDR_Q2D = 12'h0c0;
	localparam logic [11:0] ADDR_D2Q = 12'h100;

	// ==========================================================
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int PORT_TRUST_BIT = 3;
	localparam int PORT_RMK_PRIO_BIT = 4;
	localparam int PORT_RMK_DSCP_BIT = 5;
	localparam int PORT_RMK_PREC_BIT = 6;

	// ==========================================================
	// values after reset
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [23:0] RST_IDENT = 24'hfac688;
	localparam logic [7:0] RST_STRICT = 8'hff;
	localparam logic [7:0] RST_WGT = 8'h01;
	localparam logic [5:0] RST_Q2D = 6'h00;
	localparam logic [6:0] RST_PORT = 7'h08;
	localparam logic [2:0] BEST_EFFORT_Q = 3'h0;

	// ==========================================================
	// bus answers and trust modes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		TRUST_COS,
		TRUST_DSCP,
		TRUST_TAG_OR_DIFFSERV,
		TRUST_PREC
	} qcs_trust_type;

endpackage

/* File: qcs_sched.sv */
`timescale 1ns/1ns
module qcs_sched (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// selection request and queue state
	input wire logic pickReq,
	input wire logic [7:0] nonEmpty,
	input wire logic [7:0] strictMask,
	input wire logic [63:0] weights,
	// selection answer
	output logic pickValid,
	output logic [2:0] pickQueue
);
	logic [2:0] curQ_q;
	logic [7:0] credit_q;
	logic [7:0] strictHit;
	logic [7:0] wrrHit;
	logic [2:0] spQ;
	logic [2:0] rrQ;
	logic stay;

	// ==========================================================
	// candidate search
	always_comb begin
		strictHit = nonEmpty & strictMask;
		wrrHit = 8'h00;
		spQ = 3'h0;
		rrQ = curQ_q;
		for (int i = 0; i < qcs_pkg::NQ; i++) begin
			wrrHit[i] = nonEmpty[i] & ~strictMask[i]
				& (weights[i*8 +: 8] != 8'h00);
			if (strictHit[i])
				spQ = 3'(i);
		end
		// round robin order starts after the current queue
		for (int i = qcs_pkg::NQ; i >= 1; i--) begin
			if (wrrHit[3'(curQ_q + 3'(i))])
				rrQ = 3'(curQ_q + 3'(i));
		end
		stay = wrrHit[curQ_q] && (credit_q != 8'h00);
	end

	// ==========================================================
	// one grant per request, strict queues always first
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pickValid <= 1'b0;
			pickQueue <= 3'h0;
			curQ_q <= 3'h0;
			credit_q <= 8'h00;
		end else begin
			pickValid <= pickReq && ((|strictHit) || (|wrrHit));
			if (pickReq) begin
				if (|strictHit) begin
					pickQueue <= spQ;
				end else if (stay) begin
					pickQueue <= curQ_q;
					credit_q <= credit_q - 8'h01;
				end else if (|wrrHit) begin
					pickQueue <= rrQ;
					curQ_q <= rrQ;
					credit_q <= weights[rrQ*8 +: 8] - 8'h01;
				end
			end
		end
	end

endmodule

/* File: qcs_top_asserts.sv */
`timescale 1ns/1ns
module qcs_top_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// register bus handshakes
	input wire logic awvalid,
	input wire logic wvalid,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// frame paths
	input wire logic inValid,
	input wire logic [2:0] inPort,
	input wire logic clsValid,
	input wire logic [2:0] clsPort,
	input wire logic txPick,
	input wire logic [7:0] queueNonEmpty,
	input wire logic pickValid,
	input wire logic [2:0] pickQueue,
	input wire logic egValid,
	input wire logic rmkValid
);
	logic [7:0] neQ;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// backlog as it was at the request edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			neQ <= 8'h00;
		end else begin
			neQ <= queueNonEmpty;
		end
	end
	// ==========================================
	// frame and grant timing
	cls_answer_a: assert property (
		inValid |=> clsValid && clsPort == $past(inPort))
		else $error("class answer missing");
	cls_quiet_a: assert property (!inValid |=> !clsValid)
		else $error("class pulse without frame");
	pick_nonempty_a: assert property (pickValid |-> neQ[pickQueue])
		else $error("grant to empty queue");
	pick_idle_a: assert property (
		txPick && queueNonEmpty == 8'h00 |=> !pickValid)
		else $error("grant with nothing queued");
	pick_cause_a: assert property (!txPick |=> !pickValid)
		else $error("grant without request");
	rmk_follow_a: assert property (rmkValid == $past(egValid))
		else $error("remark pulse misplaced");
	// ==========================================
	// register bus answers
	write_answer_a: assert property (
		awvalid && wvalid && !bvalid |=> bvalid)
		else $error("write not answered");
	bresp_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	cover property (clsValid);
	cover property (pickValid);
	cover property (rmkValid);
	cover property (bvalid && !bready);
endmodule

bind qcs_top qcs_top_chk i_chk (
	.mclk, .nrst, .awvalid, .wvalid, .bvalid, .bready, .bresp,
	.rvalid, .rready, .rdata, .inValid, .inPort, .clsValid, .clsPort,
	.txPick, .queueNonEmpty, .pickValid, .pickQueue, .egValid, .rmkValid
);

/* File: qcs_port_model.sv */
`timescale 1ns/1ns
module qcs_port_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// backlog loading
	input wire logic loadEn,
	input wire logic [2:0] loadQ,
	input wire logic [7:0] loadN,
	// grants
	input wire logic pickValid,
	input wire logic [2:0] pickQueue,
	// backlog seen by the scheduler
	output logic [7:0] queueNonEmpty
);
	logic [7:0] backlog_q [8];
	// ==========================================
	// one packet leaves per grant, eight queues
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) begin
				backlog_q[i] <= 8'h00;
			end
		end else begin
			if (loadEn) begin
				backlog_q[loadQ] <= loadN;
			end
			if (pickValid && backlog_q[pickQueue] != 8'h00) begin
				backlog_q[pickQueue] <= backlog_q[pickQueue] - 8'h01;
			end
		end
	end
	// occupancy flags, lag one edge behind a grant
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			queueNonEmpty[i] = backlog_q[i] != 8'h00;
		end
	end
endmodule

/* File: qcs_top_tb_top.sv */
`timescale 1ns/1ns
module qcs_top_tb_top;
	logic mclk = 1'b0, nrst = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, inValid = 1'b0;
	logic inTagged = 1'b0, inIsIp = 1'b0, txPick = 1'b0;
	logic egValid = 1'b0, egIsIp = 1'b0, loadEn = 1'b0;
	logic [2:0] inPort = 3'h0, inPrio = 3'h0, egPort = 3'h0;
	logic [2:0] egQueue = 3'h0, egPrio = 3'h0, loadQ = 3'h0;
	logic [5:0] inDscp = 6'h0, egDscp = 6'h0;
	logic [7:0] loadN = 8'h00, queueNonEmpty;
	logic awready, wready, bvalid, arready, rvalid, clsValid;
	logic pickValid, rmkValid;
	logic [1:0] bresp, rresp;
	logic [2:0] clsPort, clsQueue, pickQueue, rmkPrio, q;
	logic [5:0] rmkDscp;
	int n_fail = 0, n_checks = 0, k;
	always #20 mclk = ~mclk;
	qcs_top i_dut (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .inValid,
		.inPort, .inTagged, .inPrio, .inIsIp, .inDscp, .clsValid,
		.clsPort, .clsQueue, .txPick, .queueNonEmpty, .pickValid,
		.pickQueue, .egValid, .egPort, .egQueue, .egIsIp, .egPrio,
		.egDscp, .rmkValid, .rmkPrio, .rmkDscp);
	qcs_port_model i_far (.mclk, .nrst, .loadEn, .loadQ, .loadN,
		.pickValid, .pickQueue, .queueNonEmpty);
	// ==========================================
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp, string m);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// bready raised late on purpose so the answer must wait
	task wr(input logic [11:0] a, input logic [31:0] d, logic [1:0] e);
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		// no cycle count assumed: the bvalid and bready handshake ends this wait, else the watchdog
		forever begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		bready <= 1'b0;
		chk(bresp, e, "write resp");
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, logic [1:0] er);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rready <= 1'b0;
		chk(rdata, e, "read data");
		chk(rresp, er, "read resp");
	endtask
	task cls(input logic [2:0] p, logic t, logic [2:0] pr, logic ip,
		logic [5:0] ds, logic [2:0] e);
		@(posedge mclk);
		inValid <= 1'b1;
		inPort <= p;
		inTagged <= t;
		inPrio <= pr;
		inIsIp <= ip;
		inDscp <= ds;
		@(posedge mclk);
		inValid <= 1'b0;
		@(negedge mclk);
		chk(clsValid, 1'b1, "no class");
		chk(clsQueue, e, "class queue");
	endtask
	task eg(input logic [2:0] p, logic [2:0] qu, logic ip, logic [2:0] pr,
		logic [5:0] ds, logic [2:0] ep, logic [5:0] ed);
		@(posedge mclk);
		egValid <= 1'b1;
		egPort <= p;
		egQueue <= qu;
		egIsIp <= ip;
		egPrio <= pr;
		egDscp <= ds;
		@(posedge mclk);
		egValid <= 1'b0;
		@(negedge mclk);
		chk(rmkValid, 1'b1, "no remark");
		chk(rmkPrio, ep, "remark prio");
		chk(rmkDscp, ed, "remark dscp");
	endtask
	task pk(input logic v);
		@(posedge mclk);
		txPick <= 1'b1;
		@(posedge mclk);
		txPick <= 1'b0;
		@(negedge mclk);
		chk(pickValid, v, "grant pulse");
		q = pickQueue;
	endtask
	task ld(input logic [2:0] qu, input logic [7:0] n);
		@(posedge mclk);
		loadEn <= 1'b1;
		loadQ <= qu;
		loadN <= n;
		@(posedge mclk);
		loadEn <= 1'b0;
	endtask
	task results;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task t_classify;
		rd(qcs_pkg::ADDR_P2Q, 32'hfac688, 2'h0);
		rd(12'h01c, 32'h0, qcs_pkg::RESP_SLVERR);
		wr(qcs_pkg::ADDR_STAT, 32'h1, qcs_pkg::RESP_SLVERR);
		cls(3'h0, 1'b1, 3'h7, 1'b0, 6'h00, 3'h0);
		wr(qcs_pkg::ADDR_CTRL, 32'h1, 2'h0);
		wr(qcs_pkg::ADDR_P2Q, 32'h053977, 2'h0);
		wr(qcs_pkg::ADDR_PORT + 12'h008, 32'h0d, 2'h0);
		for (k = 0; k < 8; k++) begin
			cls(3'h0, 1'b1, k[2:0], 1'b0, 6'h00, 3'h7 - k[2:0]);
		end
		cls(3'h2, 1'b0, 3'h3, 1'b0, 6'h00, 3'h2);
		cls(3'h0, 1'b1, 3'h1, 1'b1, 6'h3f, 3'h6);
		wr(qcs_pkg::ADDR_PORT + 12'h00c, 32'h0, 2'h0);
		cls(3'h3, 1'b1, 3'h7, 1'b0, 6'h00, 3'h0);
		wr(qcs_pkg::ADDR_CTRL, 32'h3, 2'h0);
		wr(qcs_pkg::ADDR_D2Q + 12'h0b8, 32'h5, 2'h0);
		cls(3'h0, 1'b1, 3'h0, 1'b1, 6'h2e, 3'h5);
		cls(3'h0, 1'b0, 3'h0, 1'b1, 6'h08, 3'h1);
		cls(3'h0, 1'b1, 3'h7, 1'b0, 6'h00, 3'h0);
		wr(qcs_pkg::ADDR_CTRL, 32'h5, 2'h0);
		cls(3'h0, 1'b1, 3'h2, 1'b0, 6'h00, 3'h5);
		cls(3'h0, 1'b1, 3'h2, 1'b1, 6'h3f, 3'h7);
		wr(qcs_pkg::ADDR_CTRL, 32'h7, 2'h0);
		wr(qcs_pkg::ADDR_PR2Q, 32'h053977, 2'h0);
		cls(3'h0, 1'b1, 3'h0, 1'b1, 6'h28, 3'h2);
		cls(3'h0, 1'b1, 3'h0, 1'b1, 6'h3f, 3'h0);
		$display("done classify");
	endtask
	task t_remark;
		wr(qcs_pkg::ADDR_CTRL, 32'h1, 2'h0);
		wr(qcs_pkg::ADDR_Q2P, 32'h053977, 2'h0);
		wr(qcs_pkg::ADDR_Q2D + 12'h00c, 32'h2a, 2'h0);
		wr(qcs_pkg::ADDR_PORT + 12'h004, 32'h38, 2'h0);
		wr(qcs_pkg::ADDR_PORT + 12'h010, 32'h48, 2'h0);
		eg(3'h1, 3'h3, 1'b1, 3'h1, 6'h11, 3'h4, 6'h2a);
		eg(3'h4, 3'h3, 1'b1, 3'h1, 6'h11, 3'h1, 6'h19);
		eg(3'h0, 3'h3, 1'b1, 3'h1, 6'h11, 3'h1, 6'h11);
		eg(3'h1, 3'h3, 1'b0, 3'h1, 6'h11, 3'h4, 6'h11);
		wr(qcs_pkg::ADDR_CTRL, 32'h0, 2'h0);
		eg(3'h1, 3'h3, 1'b1, 3'h1, 6'h11, 3'h1, 6'h11);
		$display("done remark");
	endtask
	task t_sched;
		ld(3'h0, 8'h02);
		ld(3'h4, 8'h01);
		ld(3'h7, 8'h01);
		pk(1'b1);
		chk(q, 3'h7, "strict top");
		pk(1'b1);
		chk(q, 3'h4, "strict next");
		pk(1'b1);
		pk(1'b1);
		chk(q, 3'h0, "strict low");
		pk(1'b0);
		wr(qcs_pkg::ADDR_STRICT, 32'h80, 2'h0);
		wr(qcs_pkg::ADDR_WGT + 12'h004, 32'h3, 2'h0);
		wr(qcs_pkg::ADDR_WGT + 12'h01c, 32'h5, 2'h0);
		rd(qcs_pkg::ADDR_BW + 12'h004, 32'd33, 2'h0);
		rd(qcs_pkg::ADDR_BW + 12'h01c, 32'd0, 2'h0);
		ld(3'h0, 8'h08);
		ld(3'h1, 8'h08);
		ld(3'h7, 8'h01);
		pk(1'b1);
		chk(q, 3'h7, "strict before wrr");
		k = 0;
		repeat (8) begin
			pk(1'b1);
			if (q === 3'h1) k++;
		end
		chk(k, 32'd6, "wrr share");
		$display("done sched");
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		t_classify();
		t_remark();
		t_sched();
		results();
	end
	initial begin
		#400000;
		n_fail++;
		results();
	end
endmodule
